// ---- hdl/reset_entry_and_flag_output.sv ----
`timescale 1ns/100ps
// Overview of operation
// - set instruction drives flag output high
// - clear instruction or status bit 13 lowers flag
// - flag floats only during boundary scan
// - reset abandons execution, loads reset vector
// - on release fetch vector, branch to loader
// - pull-up forced on while reset asserted
// - mode-select sampled on each rising test clock
`include "reset_flag_consts.svh"
module reset_entry_and_flag_output
  import reset_flag_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic              clock_i,                 // core clock
  input  wire logic              rstn_i,                  // power-on reset
  input  wire logic              device_reset_n_i,        // reset pin
  input  wire logic              flag_set_instruction_i,  // set pulse
  input  wire logic              flag_clear_instruction_i,// clear pulse
  input  wire logic              cpu_status_one_wr_i,     // status write
  input  wire logic [15:0]       cpu_status_one_wdata_i,  // write data
  input  wire logic              pull_inhibit_reg_two_i,  // pull-up off
  input  wire logic              test_clock_i,            // test clock pin
  input  wire logic              test_mode_select_i,      // mode-select
  input  wire logic              test_reset_n_i,          // test reset
  input  wire logic              boundary_scan_sel_i,     // scan chosen
  input  wire logic [ADDR_W-1:0] rom_data_i,              // vector word
  input  wire logic              rom_valid_i,             // word ready
  output logic                   external_flag_out_o,     // flag level
  output logic                   external_flag_oe_n_o,    // low: driven
  output logic                   internal_pullup_o,       // pull-up on
  output logic                   core_hold_o,             // stop core
  output logic                   pc_load_o,               // load pc
  output logic      [ADDR_W-1:0] pc_value_o,              // pc value
  output logic                   rom_req_o,               // vector fetch
  output logic      [ADDR_W-1:0] rom_addr_o,              // fetch address
  output logic                   boot_branch_o,           // branch pulse
  output tap_state_t             tap_state_o              // tap state
);

  localparam logic [ADDR_W-1:0] VECTOR_ADDR = `RESET_VECTOR_ADDR;

  logic [3:0]  pin_sync;
  logic        reset_pin_n;
  logic        tck_sync;
  logic        tms_sync;
  logic        trst_n_sync;
  logic        tck_prev;
  logic        tck_rise;
  logic        reset_active;
  boot_state_t boot_state;
  boot_state_t next_boot_state;
  tap_state_t  tap_state;
  tap_state_t  next_tap_state;
  logic        scan_running;

  sync_two_flop #(
    .WIDTH     (4),
    .RESET_VAL (32'h0000000C)
  ) u_pin_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i ({device_reset_n_i, test_reset_n_i,
               test_mode_select_i, test_clock_i}),
    .sync_o  (pin_sync)
  );

  assign reset_pin_n  = pin_sync[3];
  assign trst_n_sync  = pin_sync[2];
  assign tms_sync     = pin_sync[1];
  assign tck_sync     = pin_sync[0];
  assign reset_active = ~reset_pin_n;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tck_prev <= 1'h0;
    end else begin
      tck_prev <= tck_sync;
    end
  end

  assign tck_rise = tck_sync & ~tck_prev;

  // tap controller advances once per rising test clock
  always_comb begin
    next_tap_state = tap_state;
    case (tap_state)
      TAP_RESET:
        next_tap_state = tms_sync ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:
        next_tap_state = tms_sync ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:
        next_tap_state = tms_sync ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR:
        next_tap_state = tms_sync ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR:
        next_tap_state = tms_sync ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR:
        next_tap_state = tms_sync ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR:
        next_tap_state = tms_sync ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR:
        next_tap_state = tms_sync ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR:
        next_tap_state = tms_sync ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:
        next_tap_state = tms_sync ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR:
        next_tap_state = tms_sync ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR:
        next_tap_state = tms_sync ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR:
        next_tap_state = tms_sync ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR:
        next_tap_state = tms_sync ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR:
        next_tap_state = tms_sync ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR:
        next_tap_state = tms_sync ? TAP_SEL_DR : TAP_IDLE;
      default:
        next_tap_state = TAP_RESET;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tap_state <= TAP_RESET;
    end else if (!trst_n_sync) begin
      tap_state <= TAP_RESET;
    end else if (tck_rise) begin
      tap_state <= next_tap_state;
    end
  end

  assign tap_state_o  = tap_state;
  assign scan_running = boundary_scan_sel_i & trst_n_sync
                        & (tap_state != TAP_RESET);

  // set beats clear when both land in one cycle
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      external_flag_out_o <= `FLAG_RESET_VAL;
    end else if (reset_active) begin
      external_flag_out_o <= `FLAG_RESET_VAL;
    end else if (flag_set_instruction_i) begin
      external_flag_out_o <= 1'h1;
    end else if (flag_clear_instruction_i) begin
      external_flag_out_o <= 1'h0;
    end else if (cpu_status_one_wr_i) begin
      external_flag_out_o <=
        cpu_status_one_wdata_i[`STATUS_FLAG_BIT];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      external_flag_oe_n_o <= 1'h0;
    end else begin
      external_flag_oe_n_o <= scan_running;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      internal_pullup_o <= `PULLUP_RESET_VAL;
    end else begin
      internal_pullup_o <= reset_active
                           | ~pull_inhibit_reg_two_i;
    end
  end

  always_comb begin
    next_boot_state = boot_state;
    case (boot_state)
      BOOT_HOLD:
        if (!reset_active) next_boot_state = BOOT_FETCH;
      BOOT_FETCH:
        if (rom_valid_i) next_boot_state = BOOT_BRANCH;
      BOOT_BRANCH:
        next_boot_state = BOOT_RUN;
      BOOT_RUN:
        next_boot_state = BOOT_RUN;
      default:
        next_boot_state = BOOT_HOLD;
    endcase
    if (reset_active) next_boot_state = BOOT_HOLD;
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_state <= BOOT_HOLD;
    end else begin
      boot_state <= next_boot_state;
    end
  end

  // pc holds the vector address in reset, then the loader entry
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_value_o <= `PC_RESET_VAL;
    end else if (reset_active) begin
      pc_value_o <= VECTOR_ADDR;
    end else if (boot_state == BOOT_FETCH && rom_valid_i) begin
      pc_value_o <= rom_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_branch_o <= 1'h0;
    end else begin
      boot_branch_o <= (boot_state == BOOT_FETCH) & rom_valid_i
                       & ~reset_active;
    end
  end

  assign core_hold_o = (boot_state != BOOT_RUN);
  assign pc_load_o   = (boot_state == BOOT_HOLD) | boot_branch_o;
  assign rom_req_o   = (boot_state == BOOT_FETCH);
  assign rom_addr_o  = VECTOR_ADDR;

endmodule : reset_entry_and_flag_output

// ---- hdl/reset_flag_consts.svh ----
`ifndef RESET_FLAG_CONSTS_SVH
`define RESET_FLAG_CONSTS_SVH

`define RESET_VECTOR_ADDR 24'hFFFF00
`define STATUS_FLAG_BIT   4'hD
`define FLAG_RESET_VAL    1'h1
`define PULLUP_RESET_VAL  1'h1
`define PC_RESET_VAL      24'h000000

`endif

// ---- hdl/reset_flag_pkg.sv ----
package reset_flag_pkg;

  typedef enum logic [15:0] {
    TAP_RESET      = 16'h0001,
    TAP_IDLE       = 16'h0002,
    TAP_SEL_DR     = 16'h0004,
    TAP_CAPTURE_DR = 16'h0008,
    TAP_SHIFT_DR   = 16'h0010,
    TAP_EXIT1_DR   = 16'h0020,
    TAP_PAUSE_DR   = 16'h0040,
    TAP_EXIT2_DR   = 16'h0080,
    TAP_UPDATE_DR  = 16'h0100,
    TAP_SEL_IR     = 16'h0200,
    TAP_CAPTURE_IR = 16'h0400,
    TAP_SHIFT_IR   = 16'h0800,
    TAP_EXIT1_IR   = 16'h1000,
    TAP_PAUSE_IR   = 16'h2000,
    TAP_EXIT2_IR   = 16'h4000,
    TAP_UPDATE_IR  = 16'h8000
  } tap_state_t;

  typedef enum logic [3:0] {
    BOOT_HOLD   = 4'h1,
    BOOT_FETCH  = 4'h2,
    BOOT_BRANCH = 4'h4,
    BOOT_RUN    = 4'h8
  } boot_state_t;

endpackage : reset_flag_pkg

// ---- hdl/sync_two_flop.sv ----
`timescale 1ns/100ps
module sync_two_flop #(
  parameter int        WIDTH    = 1,
  parameter bit [31:0] RESET_VAL = 32'h0
) (
  input  wire logic             clock_i, // core clock
  input  wire logic             rstn_i,  // async reset, active low
  input  wire logic [WIDTH-1:0] async_i, // foreign-domain level
  output logic      [WIDTH-1:0] sync_o   // synchronised level
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_one <= RESET_VAL[WIDTH-1:0];
      sync_o    <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage_one <= async_i;
      sync_o    <= stage_one;
    end
  end

endmodule : sync_two_flop

// ---- dv/reset_flag_checker.sv ----
`timescale 1ns/100ps
`include "reset_flag_consts.svh"
module reset_flag_checker
  import reset_flag_pkg::*;
(
  input wire logic        clock_i,
                          rstn_i,
                          device_reset_n_i,
                          flag_set_instruction_i,
                          flag_clear_instruction_i,
                          cpu_status_one_wr_i,
                          test_clock_i,
                          test_mode_select_i,
                          test_reset_n_i,
                          rom_valid_i,
                          boundary_scan_sel_i,
                          external_flag_out_o,
                          external_flag_oe_n_o,
                          internal_pullup_o,
                          core_hold_o,
                          pc_load_o,
                          rom_req_o,
                          boot_branch_o,
  input wire logic [15:0] cpu_status_one_wdata_i,
  input wire logic [23:0] rom_data_i,
                          pc_value_o,
                          rom_addr_o,
  input tap_state_t       tap_state_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  sequence s_up; device_reset_n_i[*4]; endsequence
  sequence s_down; !device_reset_n_i[*4]; endsequence
  property p_set;
    s_up ##0 flag_set_instruction_i |=> external_flag_out_o; endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_clr;
    s_up ##0 !flag_set_instruction_i && (flag_clear_instruction_i ||
      cpu_status_one_wr_i && !cpu_status_one_wdata_i[13])
      |=> !external_flag_out_o; endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_flt; !boundary_scan_sel_i |=> !external_flag_oe_n_o; endproperty
  a_flt: assert property (p_flt) else $error("flag floats");
  property p_hold; s_down |-> core_hold_o && pc_load_o &&
    pc_value_o == `RESET_VECTOR_ADDR; endproperty
  a_hold: assert property (p_hold) else $error("core not held");
  property p_fetch; !device_reset_n_i ##1 s_up |-> ##[0:2]
    rom_req_o && rom_addr_o == `RESET_VECTOR_ADDR; endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch");
  property p_jump; rom_req_o && rom_valid_i |=> (boot_branch_o && pc_load_o
    && pc_value_o == $past(rom_data_i)) ##1 !core_hold_o; endproperty
  a_jump: assert property (p_jump) else $error("no branch");
  property p_pull; s_down |-> internal_pullup_o; endproperty
  a_pull: assert property (p_pull) else $error("pull-up off");
  property p_tap; tap_state_o == TAP_RESET && !test_mode_select_i &&
    test_reset_n_i && $rose(test_clock_i) |-> ##[1:6]
    tap_state_o == TAP_IDLE; endproperty
  a_tap: assert property (p_tap) else $error("tap stuck");
  property p_sync; $rose(device_reset_n_i) |-> !rom_req_o[*2]; endproperty
  a_sync: assert property (p_sync) else $error("early fetch");
endmodule : reset_flag_checker

// ---- dv/vector_rom_model.sv ----
`timescale 1ns/100ps
`include "reset_flag_consts.svh"
module vector_rom_model #(
  parameter logic [23:0] ENTRY = 24'h00A5C3
) (
  input  wire logic        clock_i, // core clock
  input  wire logic        slow_i,  // answer late
  input  wire logic        req_i,   // fetch request
  input  wire logic [23:0] addr_i,  // fetch address
  output logic             valid_o, // word ready
  output logic      [23:0] data_o   // vector word
);
  logic [1:0] wait_n = 2'h0;
  initial valid_o = 1'b0;
  initial data_o = 24'h5A5A5A;
  // word shown one cycle only; idle lines toggle every cycle
  always @(posedge clock_i) begin
    if (valid_o) begin
      valid_o <= 1'b0;
      data_o  <= ~data_o;
    end else if (req_i && wait_n == 2'h0) begin
      valid_o <= 1'b1;
      data_o  <= addr_i == `RESET_VECTOR_ADDR ? ENTRY : ~ENTRY;
    end else if (req_i) begin
      wait_n <= wait_n - 2'h1;
    end else begin
      wait_n <= slow_i ? 2'h3 : 2'h0;
      data_o <= ~data_o;
    end
  end
endmodule : vector_rom_model

// ---- dv/test_reset_entry_and_flag_output.sv ----
`timescale 1ns/100ps
`include "reset_flag_consts.svh"
module test_reset_entry_and_flag_output
  import reset_flag_pkg::*;
;
  localparam logic [23:0] ENTRY = 24'h00A5C3;
  logic clock_i = 1'b0, rstn_i = 1'b0, device_reset_n_i = 1'b1, slow = 1'b0;
  logic flag_set_instruction_i = 1'b0, flag_clear_instruction_i = 1'b0;
  logic cpu_status_one_wr_i = 1'b0, pull_inhibit_reg_two_i = 1'b0;
  logic test_clock_i = 1'b0, test_mode_select_i = 1'b1;
  logic test_reset_n_i = 1'b0, boundary_scan_sel_i = 1'b0;
  logic [15:0] cpu_status_one_wdata_i = 16'h0000;
  logic [23:0] rom_data_i, pc_value_o, rom_addr_o;
  logic rom_valid_i, external_flag_out_o, external_flag_oe_n_o, pc_load_o;
  logic internal_pullup_o, core_hold_o, rom_req_o, boot_branch_o;
  tap_state_t tap_state_o;
  int err_total = 0, n_checks = 0, cycles = 0;
  reset_entry_and_flag_output dut (.clock_i, .rstn_i, .device_reset_n_i,
    .flag_set_instruction_i, .flag_clear_instruction_i, .cpu_status_one_wr_i,
    .cpu_status_one_wdata_i, .pull_inhibit_reg_two_i, .test_clock_i,
    .test_mode_select_i, .test_reset_n_i, .boundary_scan_sel_i, .rom_data_i,
    .rom_valid_i, .external_flag_out_o, .external_flag_oe_n_o,
    .internal_pullup_o, .core_hold_o, .pc_load_o, .pc_value_o, .rom_req_o,
    .rom_addr_o, .boot_branch_o, .tap_state_o);
  vector_rom_model #(.ENTRY(ENTRY)) rom (.clock_i, .slow_i(slow),
    .req_i(rom_req_o), .addr_i(rom_addr_o), .valid_o(rom_valid_i),
    .data_o(rom_data_i));
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input logic [23:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_tap(input tap_state_t got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: tap %h want %h", $time, got, exp);
    end
  endtask : chk_tap
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  task automatic step(input logic s, c, w, b, e);
    flag_set_instruction_i = s;
    flag_clear_instruction_i = c;
    cpu_status_one_wr_i = w;
    cpu_status_one_wdata_i = {2'h0, b, 13'h0000};
    cyc(1);
    chk_bit(external_flag_out_o, e);
  endtask : step
  task automatic t_flag();
    step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    step(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    step(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    step(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("t_flag done");
  endtask : t_flag
  task automatic t_boot(input logic sl);
    slow = sl;
    pull_inhibit_reg_two_i = 1'b1;
    cyc(4);
    chk_bit(internal_pullup_o, 1'b0);
    device_reset_n_i = 1'b0;
    cyc(5);
    chk_bit(internal_pullup_o, 1'b1);
    chk_bit(core_hold_o, 1'b1);
    chk_bit(pc_load_o, 1'b1);
    chk(pc_value_o, `RESET_VECTOR_ADDR);
    device_reset_n_i = 1'b1;
    cyc(2);
    chk_bit(rom_req_o, 1'b0);
    cyc(1);
    chk_bit(rom_req_o, 1'b1);
    chk(rom_addr_o, `RESET_VECTOR_ADDR);
    for (int i = 0; i < 12 && boot_branch_o !== 1'b1; i++) cyc(1);
    chk_bit(boot_branch_o, 1'b1);
    chk_bit(pc_load_o, 1'b1);
    chk(pc_value_o, ENTRY);
    cyc(1);
    chk_bit(core_hold_o, 1'b0);
    chk_bit(pc_load_o, 1'b0);
    pull_inhibit_reg_two_i = 1'b0;
    $display("t_boot done");
  endtask : t_boot
  task automatic t_scan();
    test_reset_n_i = 1'b1;
    test_mode_select_i = 1'b0;
    boundary_scan_sel_i = 1'b1;
    cyc(6);
    chk_bit(external_flag_oe_n_o, 1'b0);
    test_clock_i = 1'b1;
    cyc(8);
    chk_tap(tap_state_o, TAP_IDLE);
    chk_bit(external_flag_oe_n_o, 1'b1);
    test_clock_i = 1'b0;
    test_mode_select_i = 1'b1;
    cyc(4);
    test_clock_i = 1'b1;
    cyc(4);
    chk_tap(tap_state_o, TAP_SEL_DR);
    test_clock_i = 1'b0;
    boundary_scan_sel_i = 1'b0;
    cyc(2);
    chk_bit(external_flag_oe_n_o, 1'b0);
    test_reset_n_i = 1'b0;
    cyc(3);
    chk_tap(tap_state_o, TAP_RESET);
    $display("t_scan done");
  endtask : t_scan
  initial begin
    cyc(10);
    rstn_i = 1'b1;
    cyc(2);
    chk_tap(tap_state_o, TAP_RESET);
    t_boot(1'b0);
    t_flag();
    t_boot(1'b1);
    t_scan();
    test_done();
  end
endmodule : test_reset_entry_and_flag_output
bind reset_entry_and_flag_output reset_flag_checker chk_u (.clock_i,
  .rstn_i, .device_reset_n_i, .flag_set_instruction_i,
  .flag_clear_instruction_i, .cpu_status_one_wr_i, .test_clock_i,
  .test_mode_select_i, .test_reset_n_i, .rom_valid_i, .boundary_scan_sel_i,
  .external_flag_out_o, .external_flag_oe_n_o, .internal_pullup_o,
  .core_hold_o, .pc_load_o, .rom_req_o, .boot_branch_o,
  .cpu_status_one_wdata_i, .rom_data_i, .pc_value_o, .rom_addr_o,
  .tap_state_o);
